// *** rtl/sdsr_sequencer.sv ***
// SDRAM single-word read sequencer with read-data FIFO
// Behaviour
// - SDRAM clock runs at the sequencer clock rate, mclk; timing counted in its cycles.
// - A read to a row not yet open starts with a bank activate that opens the row.
// - Read command, CAS low, follows the activate by three cycles.
// - Burst terminate, WE low, issued the cycle right after the read.
// - Read word captured on the third clock after the read command.
// - Next read command comes six cycles after the previous word is captured.
// - One 16-bit read completes every ten cycles on an open row.
// - First read, or read to a new row, pays three extra activate cycles.
// - Sequencer clock mclk, also SDRAM clock, nominally 40 MHz; traffic controller clock 75 MHz.
`timescale 1ns/1ps
`default_nettype none
module sdsr_sequencer (
   input wire logic mclk, // Clock, also forwarded as SDRAM clock
   input wire logic rst, // Asynchronous reset, active high
   input wire logic reqValid, // Read request offered
   output logic reqReady, // Sequencer takes a request
   input wire logic [sdsr_pkg::BANK_W-1:0] reqBank, // Request bank
   input wire logic [sdsr_pkg::ROW_W-1:0] reqRow, // Request row
   input wire logic [sdsr_pkg::COL_W-1:0] reqCol, // Request column
   output logic rdValid, // Read word present
   input wire logic rdReady, // Consumer takes the read word
   output logic [sdsr_pkg::DATA_W-1:0] rdData, // Read word
   output logic sdClkEn, // Enable of the forwarded SDRAM clock
   output logic sdCsN, // Chip select, low active
   output logic sdRasN, // Row strobe, low active
   output logic sdCasN, // Column strobe, low active
   output logic sdWeN, // Write enable, low active
   output logic [sdsr_pkg::BANK_W-1:0] sdBank, // Bank address
   output logic [sdsr_pkg::ROW_W-1:0] sdAddr, // Multiplexed address
   input wire logic [sdsr_pkg::DATA_W-1:0] sdDq // Read data from SDRAM
);
   import sdsr_pkg::*;

   typedef struct packed {
      sdsr_state_t st;
      logic [3:0] cnt;
      logic reqReady;
      logic clkEn;
      logic csN;
      logic rasN;
      logic casN;
      logic weN;
      logic [BANK_W-1:0] bank;
      logic [ROW_W-1:0] addr;
      logic [COL_W-1:0] col;
      logic openValid;
      logic [BANK_W-1:0] openBank;
      logic [ROW_W-1:0] openRow;
      logic wrValid;
      logic [DATA_W-1:0] wrData;
   } sdsr_seq_t;

   sdsr_seq_t s_reg;
   sdsr_seq_t s_next;
   logic fifoInReady;
   logic take;
   logic rowHit;

   // ==========================================================
   // Cycle plan, counted from the edge that takes a request (cycle 0)
   // Row miss:
   //    c1       activate, row on the address pins
   //    c2, c3   no command while the row opens
   //    c4       read, column on the address pins
   //    c5       burst terminate, so only one word comes back
   //    c6       no command, the word still in flight
   //    end c7   word sampled from the data pins
   //    c8       word pushed into the buffer
   //    c8-c12   quiet gap while the counter runs down
   //    c13      ready again; a take here puts the next command in c14
   // Row hit:
   //    c1       read at once, the row being open already
   //    c2       burst terminate
   //    end c4   word sampled
   //    c10      ready again; the next command comes in c11 at the earliest
   // Reads on an open row are thus ten cycles apart; a row change costs
   // three more for the activate.
   // Hazards and limitations:
   //    Only one bank and row pair is remembered, that of the last activate.
   //    No precharge goes out on a row change; a miss simply activates, so
   //    the far side must accept an activate onto a bank with a row open.
   //    The counter is four bits wide, ample for the spacing used here.
   //    Strobes return high every cycle unless a state drives one low, so a
   //    stray state can never hold a command on the pins.

   // ==========================================================
   // Command sequencing
   // A request is only taken while the FIFO has room; with one read in
   // flight that room is still there when the word lands.
   always_comb begin
      s_next = s_reg;
      s_next.rasN = CMD_IDLE_N;
      s_next.casN = CMD_IDLE_N;
      s_next.weN = CMD_IDLE_N;
      s_next.wrValid = 1'b0;
      s_next.clkEn = 1'b1;
      s_next.csN = 1'b0;
      take = reqValid && s_reg.reqReady;
      rowHit = s_reg.openValid && (s_reg.openBank == reqBank) && (s_reg.openRow == reqRow);
      unique case (s_reg.st)
         ST_IDLE: begin
            // Idle: ready follows the room left in the buffer
            if (take) begin
               s_next.reqReady = 1'b0;
               s_next.bank = reqBank;
               s_next.col = reqCol;
               if (rowHit) begin
                  // Open row: go straight to the read
                  s_next.casN = 1'b0;
                  s_next.addr = {{(ROW_W-COL_W){1'b0}}, reqCol};
                  s_next.st = ST_TERM;
               end else begin
                  s_next.rasN = 1'b0;
                  s_next.addr = reqRow;
                  s_next.openValid = 1'b1;
                  s_next.openBank = reqBank;
                  s_next.openRow = reqRow;
                  // Counter spans the whole row opening, so the read lands in c4
                  s_next.cnt = ACT_TO_READ;
                  s_next.st = ST_ACTWAIT;
               end
            end else begin
               s_next.reqReady = fifoInReady;
            end
         end
         ST_ACTWAIT: begin
            // Row opening: the read goes out once the count reaches one
            if (s_reg.cnt == 4'h1) begin
               s_next.casN = 1'b0;
               s_next.addr = {{(ROW_W-COL_W){1'b0}}, s_reg.col};
               s_next.st = ST_TERM;
            end
            s_next.cnt = s_reg.cnt - 4'h1;
         end
         ST_TERM: begin
            // Stop the burst at once, so the SDRAM returns a single word
            s_next.weN = 1'b0;
            // Two more counted cycles put the sample on the third edge after the read
            s_next.cnt = READ_TO_LATCH - 4'h1;
            s_next.st = ST_LATCH;
         end
         ST_LATCH: begin
            // Wait out the column latency with no command on the pins
            if (s_reg.cnt == 4'h0) begin
               s_next.wrValid = 1'b1;
               s_next.wrData = sdDq;
               // Ready then stands in the sixth cycle after the sample
               s_next.cnt = LATCH_TO_NEXT - 4'h2;
               s_next.st = ST_GAP;
            end else begin
               s_next.cnt = s_reg.cnt - 4'h1;
            end
         end
         ST_GAP: begin
            // Six idle cycles give ten cycles read to read on an open row
            if (s_reg.cnt == 4'h0) begin
               s_next.reqReady = fifoInReady;
               s_next.st = ST_IDLE;
            end else begin
               s_next.cnt = s_reg.cnt - 4'h1;
            end
         end
         default: begin
            s_next.st = ST_IDLE;
         end
      endcase
   end

   // ==========================================================
   // State register
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         // Pins leave reset idle, with the SDRAM clock gated off
         s_reg <= '0;
         s_reg.st <= ST_IDLE;
         s_reg.csN <= CMD_IDLE_N;
         s_reg.rasN <= CMD_IDLE_N;
         s_reg.casN <= CMD_IDLE_N;
         s_reg.weN <= CMD_IDLE_N;
         s_reg.addr <= ADDR_RST;
         s_reg.bank <= BANK_RST;
      end else begin
         s_reg <= s_next;
      end
   end

   // ==========================================================
   // Read data buffer
   // Depth 32 plus its output register; the ready path keeps it from overflowing
   sdsr_fifo #(
      .WIDTH(DATA_W),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .mclk(mclk),
      .rst(rst),
      .inValid(s_reg.wrValid),
      .inReady(fifoInReady),
      .inData(s_reg.wrData),
      .outValid(rdValid),
      .outReady(rdReady),
      .outData(rdData)
   );

   // ==========================================================
   // Pins and handshake straight from the state register
   assign reqReady = s_reg.reqReady;
   assign sdClkEn = s_reg.clkEn;
   assign sdCsN = s_reg.csN;
   assign sdRasN = s_reg.rasN;
   assign sdCasN = s_reg.casN;
   assign sdWeN = s_reg.weN;
   assign sdBank = s_reg.bank;
   assign sdAddr = s_reg.addr;
endmodule : sdsr_sequencer
`default_nettype wire

// *** common/sdsr_pkg.sv ***
// Package: constants and types of the SDRAM single-read sequencer
package sdsr_pkg;
   // ==========================================================
   // Widths
   localparam int DATA_W = 16;
   localparam int ROW_W = 13;
   localparam int COL_W = 9;
   localparam int BANK_W = 2;
   localparam int FIFO_DEPTH = 32;
   // ==========================================================
   // Clock rates, for reference; all spacing below is in clock cycles
   localparam int TC_CLK_MHZ = 75;
   localparam int MCLK_MHZ = 40;
   // ==========================================================
   // Command spacing in clock cycles
   localparam logic [3:0] ACT_TO_READ = 4'h3;
   localparam logic [3:0] READ_TO_LATCH = 4'h3;
   localparam logic [3:0] LATCH_TO_NEXT = 4'h6;
   // ==========================================================
   // Reset values of the pins
   localparam logic CMD_IDLE_N = 1'b1;
   localparam logic [ROW_W-1:0] ADDR_RST = 13'h0000;
   localparam logic [BANK_W-1:0] BANK_RST = 2'h0;
   // ==========================================================
   // Sequencer states
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_ACTWAIT = 3'b001,
      ST_TERM = 3'b010,
      ST_LATCH = 3'b011,
      ST_GAP = 3'b100
   } sdsr_state_t;
endpackage : sdsr_pkg

// *** rtl/sdsr_fifo.sv ***
// Read-data FIFO with registered output word
`timescale 1ns/1ps
`default_nettype none
module sdsr_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 32
) (
   input wire logic mclk, // Clock
   input wire logic rst, // Asynchronous reset, active high
   input wire logic inValid, // Write word offered
   output logic inReady, // Room for a word
   input wire logic [WIDTH-1:0] inData, // Word written
   output logic outValid, // Output word present
   input wire logic outReady, // Consumer takes the word
   output logic [WIDTH-1:0] outData // Output word
);
   localparam int AW = $clog2(DEPTH);
   typedef struct packed {
      logic [AW-1:0] wrPtr;
      logic [AW-1:0] rdPtr;
      logic [AW:0] count;
      logic outValid;
      logic [WIDTH-1:0] outData;
   } sdsr_fifo_t;
   sdsr_fifo_t s_reg;
   sdsr_fifo_t s_next;
   logic [WIDTH-1:0] mem [DEPTH];
   logic push;
   logic pop;

   // ==========================================================
   // Pointer and output register updates
   always_comb begin
      s_next = s_reg;
      push = inValid && (s_reg.count != (AW+1)'(DEPTH));
      // The output register refills whenever a word is stored and the register is empty or being drained
      pop = (s_reg.count != '0) && (!s_reg.outValid || outReady);
      if (push) begin
         s_next.wrPtr = s_reg.wrPtr + 1'b1;
      end
      if (pop) begin
         s_next.rdPtr = s_reg.rdPtr + 1'b1;
         s_next.outData = mem[s_reg.rdPtr];
         s_next.outValid = 1'b1;
      end else if (outReady) begin
         s_next.outValid = 1'b0;
      end
      s_next.count = s_reg.count + (AW+1)'(push) - (AW+1)'(pop);
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end

   // Storage has no reset, so it maps onto plain RAM
   always_ff @(posedge mclk) begin
      if (push) begin
         mem[s_reg.wrPtr] <= inData;
      end
   end

   assign inReady = (s_reg.count != (AW+1)'(DEPTH));
   assign outValid = s_reg.outValid;
   assign outData = s_reg.outData;
endmodule : sdsr_fifo
`default_nettype wire

// *** test/sdsr_sequencer_asserts.sv ***
// Checker: SDRAM command timing seen at the sequencer ports
`timescale 1ns/1ps
`default_nettype none
module sdsr_sequencer_asserts (
   input wire logic mclk, // Clock
   input wire logic rst, // Reset
   input wire logic reqValid, // Request offered
   input wire logic reqReady, // Request taken
   input wire logic sdClkEn, // SDRAM clock enable
   input wire logic sdCsN, // Chip select
   input wire logic sdRasN, // Row strobe
   input wire logic sdCasN, // Column strobe
   input wire logic sdWeN, // Write enable
   input wire logic rdValid, // Word present
   input wire logic rdReady // Word taken
);
   // ==========================================================
   // Command spacing, counted in sequencer clocks
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);
   a_clk_cs_on: assert property (!rst |=> sdClkEn && !sdCsN)
      else $error("clock or select off");
   a_take_cmd: assert property (reqValid && reqReady |=> !sdRasN || !sdCasN)
      else $error("no command after take");
   a_act_to_read: assert property (!sdRasN |-> ##3 !sdCasN) else $error("read late");
   a_read_term: assert property (!sdCasN |=> !sdWeN) else $error("no burst stop");
   a_one_cmd: assert property ($countones({sdRasN, sdCasN, sdWeN}) >= 2)
      else $error("two strobes low");
   // A hit may repeat a read only ten cycles on, so nine quiet cycles follow
   a_read_gap: assert property (!sdCasN |=> sdCasN [*8] ##1 sdCasN)
      else $error("reads too close");
   a_act_gap: assert property (!sdRasN |=> sdRasN [*8] ##1 sdRasN)
      else $error("activates too close");
   a_ready_hold: assert property (!sdCasN |-> !reqReady [*8] ##1 !reqReady)
      else $error("ready too early");
   c_miss: cover property (!sdRasN ##3 !sdCasN);
   c_hit_pair: cover property (!sdCasN ##10 !sdCasN);
   c_full: cover property (rdValid && !rdReady && !reqReady);
endmodule : sdsr_sequencer_asserts
bind sdsr_sequencer sdsr_sequencer_asserts sdsr_sequencer_asserts_i (.mclk, .rst, .reqValid,
   .reqReady, .sdClkEn, .sdCsN, .sdRasN, .sdCasN, .sdWeN, .rdValid, .rdReady);
`default_nettype wire

// *** test/sdsr_sdram_model.sv ***
// Behavioural SDRAM answering single-word reads
`timescale 1ns/1ps
`default_nettype none
module sdsr_sdram_model (
   input wire logic mclk, // SDRAM clock
   input wire logic sdCsN, // Chip select
   input wire logic sdRasN, // Row strobe
   input wire logic sdCasN, // Column strobe
   input wire logic sdWeN, // Write enable
   input wire logic [sdsr_pkg::BANK_W-1:0] sdBank, // Bank
   input wire logic [sdsr_pkg::ROW_W-1:0] sdAddr, // Address
   output logic [sdsr_pkg::DATA_W-1:0] sdDq // Read data
);
   import sdsr_pkg::*;
   logic [ROW_W-1:0] rowReg [4];
   logic [2:0] pipeReg = 3'h0;
   logic [DATA_W-1:0] wordReg;
   initial sdDq = 16'h0000;
   // ==========================================================
   // Decode; the word mixes bank, row and column so a wrong address shows
   always @(posedge mclk) begin
      if (!sdCsN && !sdRasN && sdCasN && sdWeN) rowReg[sdBank] <= sdAddr;
      pipeReg <= {pipeReg[1:0], !sdCsN && sdRasN && !sdCasN && sdWeN};
      if (!sdCasN) wordReg <= {sdBank, rowReg[sdBank][4:0], sdAddr[8:0]};
   end
   // Word valid only for the third edge after the read; the bus toggles otherwise
   always @(posedge mclk) #1 sdDq <= pipeReg[2] ? wordReg : ~sdDq;
endmodule : sdsr_sdram_model
`default_nettype wire

// *** test/sdsr_sequencer_tb.sv ***
// Self-checking bench of the SDRAM single-read sequencer
`timescale 1ns/1ps
`default_nettype none
module sdsr_sequencer_tb;
   import sdsr_pkg::*;
   logic mclk = 0, rst = 1, reqValid = 0, rdReady = 0, stall = 0;
   logic reqReady, rdValid, sdClkEn, sdCsN, sdRasN, sdCasN, sdWeN;
   logic [BANK_W-1:0] reqBank = 0, sdBank;
   logic [ROW_W-1:0] reqRow = 0, sdAddr;
   logic [COL_W-1:0] reqCol = 0;
   logic [DATA_W-1:0] rdData, sdDq;
   logic [DATA_W-1:0] wordQ[$];
   logic [BANK_W+ROW_W:0] prev = '1; // Top bit set: no row open yet
   int gapQ[$];
   int fail_count = 0, samples_checked = 0, cyc = 0, lastRd = 0, g;
   sdsr_sequencer sdsr_sequencer_i (.mclk, .rst, .reqValid, .reqReady, .reqBank, .reqRow,
      .reqCol, .rdValid, .rdReady, .rdData, .sdClkEn, .sdCsN, .sdRasN, .sdCasN, .sdWeN,
      .sdBank, .sdAddr, .sdDq);
   sdsr_sdram_model sdsr_sdram_model_i (.mclk, .sdCsN, .sdRasN, .sdCasN, .sdWeN, .sdBank,
      .sdAddr, .sdDq);
   initial forever #12.5 mclk = ~mclk;
   // ==========================================================
   // Helpers
   task automatic chk(input string name, input logic [DATA_W-1:0] exp, got);
      samples_checked++;
      if (got !== exp) begin
         fail_count++;
         $display("mismatch %s expected %h seen %h", name, exp, got);
      end
   endtask : chk
   // Offer a read and hold it until taken; gap 0 means spacing is not judged
   task automatic rd(input logic [BANK_W-1:0] b, input logic [ROW_W-1:0] r, input int tight);
      logic [COL_W-1:0] c;
      c = COL_W'($urandom);
      gapQ.push_back(!tight ? 0 : (prev == {1'b0, b, r}) ? 10 : 13);
      wordQ.push_back({b, r[4:0], c});
      prev = {1'b0, b, r};
      reqValid <= 1;
      reqBank <= b;
      reqRow <= r;
      reqCol <= c;
      do @(posedge mclk); while (!reqReady);
   endtask : rd
   task automatic finish_test();
      $display("checks %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : finish_test
   // Consumer takes words at random, or not at all while the buffer fills
   always @(posedge mclk) rdReady <= !stall && ($urandom % 4 != 0);
   // Scoreboard: words in request order, and spacing of read commands
   always @(posedge mclk) begin
      cyc++;
      if (!rst && rdValid && rdReady) chk("rdData", wordQ.pop_front(), rdData);
      if (!rst && !sdCsN && !sdCasN) begin
         g = gapQ.pop_front();
         if (g != 0) chk("readGap", 16'(g), 16'(cyc - lastRd));
         lastRd = cyc;
      end
   end
   // ==========================================================
   // Tests
   initial begin
      void'($urandom(68815));
      repeat (16) @(posedge mclk);
      rst <= 0;
      repeat (2) @(posedge mclk);
      // Eight reads on one row, the first a miss and seven hits, then a new random row each time
      for (int i = 0; i < 24; i++) rd(i < 8 ? 2'h1 : BANK_W'($urandom),
         i < 8 ? 13'h00A5 : ROW_W'($urandom), i != 0);
      reqValid <= 0;
      while (wordQ.size() != 0) @(posedge mclk);
      // Fill the stalled buffer to its 33 words, then expect refusal
      stall <= 1;
      for (int i = 0; i < 33; i++) rd(2'h2, 13'h1FFF, i != 0);
      reqValid <= 0;
      repeat (60) @(posedge mclk) chk("reqReady", 16'h0000, {15'h0000, reqReady});
      stall <= 0;
      rd(2'h2, 13'h1FFF, 0);
      reqValid <= 0;
      while (wordQ.size() != 0) @(posedge mclk);
      finish_test();
   end
   // Watchdog: the sequence needs under 1500 cycles
   initial begin
      #(25 * 5000);
      fail_count++;
      finish_test();
   end
endmodule : sdsr_sequencer_tb
`default_nettype wire
